// >>> verilog/nvsp_host.v
/*
 * nvsp_host: host controller driving a nonvolatile sram through its
 * asynchronous strobes: reads, writes, software save and restore.
 * assumes the pins are wired directly; hw_save_strobe_n is open drain
 * shared with the device, and data_lines splits into in/out/enable.
 */
// Notes on behaviour
// [RL1] write strobe stays high during reads
// [RL2] device data follows address when selected
// [RL3] write low at select fall: outputs float
// [RL4] save strobe high during sram cycles
// [RL5] address changes only with select high
// [RL6] device skips save without prior write
// [RL7] sram usable briefly after save trigger
// [RL8] device ignores access during nonvolatile cycle
// [RL9] power-up restore done within 20 ms
// [RL10] supply below trip level triggers save
// [RL11] save strobe pulled high by resistor
// [RL12] sequence reads spaced by read cycle
// [RL13] six sequence reads, write strobe high
// [RL14] sequence steps are ordinary reads
// [RL15] lane selects gate low and high bytes
// [RL16] select high means deselected, data floats
// [RL17] sequence addresses come from parameter table
// [RL18] hold new accesses during nonvolatile cycle
`include "nvsp_map.vh"
module nvsp_host #(
   parameter AW             = 18,
   parameter DW             = 16,
   parameter PWRUP_CYCLES   = 500000,   // 20 ms at 25 mhz
   parameter STORE_CYCLES   = 200000,   // 8 ms at 25 mhz
   parameter RECALL_CYCLES  = 5000,     // 200 us at 25 mhz
   parameter [6*AW-1:0] SAVE_SEQ    = {6{18'h00000}},
   parameter [6*AW-1:0] RESTORE_SEQ = {6{18'h00000}}
) (
   input  wire          core_clk,
   input  wire          rst,
   input  wire          clk_en,
   input  wire          req_valid,
   output wire          req_ready,
   input  wire [1:0]    req_op,
   input  wire [AW-1:0] req_addr,
   input  wire [DW-1:0] req_wdata,
   input  wire [1:0]    req_lane_n,
   output reg           rsp_valid,
   output reg  [DW-1:0] rsp_rdata,
   output reg           nv_busy,
   output reg  [AW-1:0] mem_addr,
   output reg           chip_sel_n,
   output reg           write_n,
   output reg           out_gate_n,
   output reg           upper_lane_sel_n,
   output reg           lower_lane_sel_n,
   input  wire [DW-1:0] data_lines_in,
   output reg  [DW-1:0] data_lines_out,
   output reg           data_lines_oe,
   input  wire          hw_save_strobe_n_in,
   output wire          hw_save_strobe_n_out,
   output wire          hw_save_strobe_n_oe
);
   // strobe widths in clocks, least times rounded up
   localparam RD_NS_CYC = (`NVSP_READ_CYCLE_NS + `NVSP_CLK_NS - 1) / `NVSP_CLK_NS;
   localparam WR_NS_CYC = (`NVSP_WRITE_PULSE_NS + `NVSP_CLK_NS - 1) / `NVSP_CLK_NS;
   localparam SP_NS_CYC = (`NVSP_SEQ_SPACING_NS + `NVSP_CLK_NS - 1) / `NVSP_CLK_NS;
   // counter-width copies; every count fits the four-bit phase counter
   localparam [3:0] RD_CYC = RD_NS_CYC[3:0];
   localparam [3:0] WR_CYC = WR_NS_CYC[3:0];
   localparam [3:0] SP_CYC = SP_NS_CYC[3:0];

   // states
   localparam [2:0] S_PWRUP = 3'h0;   // waiting out power-up restore
   localparam [2:0] S_IDLE  = 3'h1;   // ready for a request
   localparam [2:0] S_SETUP = 3'h2;   // address settled, strobes high
   localparam [2:0] S_STRB  = 3'h3;   // strobes low
   localparam [2:0] S_END   = 3'h4;   // strobes released
   localparam [2:0] S_NV    = 3'h5;   // nonvolatile cycle running

   reg [2:0]    state_r;        // current state
   reg [1:0]    op_r;           // latched operation
   reg [3:0]    wait_r;         // strobe phase counter
   reg [2:0]    step_r;         // sequence step index
   reg          save_sync0_r;   // strobe pin, first stage
   reg          save_sync1_r;   // strobe pin, second stage
   reg          tload;          // timer load
   reg [19:0]   tval;           // timer value
   wire         tdone;          // timer expired
   wire [AW-1:0] seq_addr;      // next sequence address

   // host never pulls the save strobe; device pullup holds it high [RL4] [RL11]
   assign hw_save_strobe_n_out = 1'b1;
   assign hw_save_strobe_n_oe  = 1'b0;

   // only idle takes new requests, so accesses wait out nv cycles [RL18] [RL8]
   assign req_ready = (state_r == S_IDLE) & clk_en;

   // next sequence address from the parameter table [RL17]
   // step five never reads it, so the slot past the table stays unused
   assign seq_addr = (op_r == `NVSP_OP_SAVE) ?
                     SAVE_SEQ[(step_r+3'h1)*AW +: AW] : RESTORE_SEQ[(step_r+3'h1)*AW +: AW];

   nvsp_timer #(.W(20)) u_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (clk_en),
      .load     (tload),
      .value    (tval),
      .done     (tdone)
   );

   // timer loads: power-up wait after reset, nv duration after sequence
   always @* begin
      tload = 1'b0;
      tval  = 20'h00000;
      if (state_r == S_END && wait_r == 4'h0 &&
          (op_r == `NVSP_OP_SAVE || op_r == `NVSP_OP_RESTORE) &&
          step_r == 3'h5) begin
         tload = 1'b1;
         // save covers a possible skip too: waiting is always safe [RL6]
         tval  = (op_r == `NVSP_OP_SAVE) ? STORE_CYCLES[19:0] : RECALL_CYCLES[19:0];
      end else if (state_r == S_PWRUP && save_sync1_r && wait_r == 4'h1) begin
         tload = 1'b1;
         tval  = PWRUP_CYCLES[19:0];   // [RL9]
      end
   end

   // strobe pin synchroniser, used to see the device release it
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         save_sync0_r <= 1'b0;
         save_sync1_r <= 1'b0;
      end else if (clk_en) begin
         save_sync0_r <= hw_save_strobe_n_in;
         save_sync1_r <= save_sync0_r;
      end
   end

   // main sequencer
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r          <= S_PWRUP;
         op_r             <= `NVSP_OP_READ;
         wait_r           <= 4'h1;
         step_r           <= 3'h0;
         rsp_valid        <= 1'b0;
         rsp_rdata        <= {DW{1'b0}};
         nv_busy          <= 1'b1;
         mem_addr         <= {AW{1'b0}};
         chip_sel_n       <= 1'b1;
         write_n          <= 1'b1;
         out_gate_n       <= 1'b1;
         upper_lane_sel_n <= 1'b1;
         lower_lane_sel_n <= 1'b1;
         data_lines_out   <= {DW{1'b0}};
         data_lines_oe    <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         case (state_r)
            S_PWRUP: begin
               // trip level and restore happen inside the part [RL10]
               if (wait_r == 4'h1) begin
                  if (save_sync1_r) begin
                     wait_r <= 4'h0;
                  end
               end else if (tdone) begin
                  state_r <= S_IDLE;
                  nv_busy <= 1'b0;
               end
            end
            S_IDLE: begin
               if (req_valid) begin
                  op_r     <= req_op;
                  step_r   <= 3'h0;
                  state_r  <= S_SETUP;
                  // address moves only while select is high [RL5] [RL16]
                  if (req_op == `NVSP_OP_READ || req_op == `NVSP_OP_WRITE) begin
                     mem_addr         <= req_addr;
                     upper_lane_sel_n <= req_lane_n[1];   // [RL15]
                     lower_lane_sel_n <= req_lane_n[0];   // [RL15]
                  end else begin
                     mem_addr         <= (req_op == `NVSP_OP_SAVE) ?
                                         SAVE_SEQ[AW-1:0] : RESTORE_SEQ[AW-1:0];
                     upper_lane_sel_n <= 1'b0;
                     lower_lane_sel_n <= 1'b0;
                     nv_busy          <= 1'b1;
                  end
                  data_lines_out <= req_wdata;
               end
            end
            S_SETUP: begin
               // select falls with write already decided [RL3]
               chip_sel_n <= 1'b0;
               if (op_r == `NVSP_OP_WRITE) begin
                  write_n       <= 1'b0;
                  data_lines_oe <= 1'b1;
                  wait_r        <= WR_CYC;
               end else begin
                  write_n    <= 1'b1;   // reads and sequence steps [RL1] [RL13] [RL14]
                  out_gate_n <= 1'b0;
                  wait_r     <= RD_CYC;
               end
               state_r <= S_STRB;
            end
            S_STRB: begin
               if (wait_r > 4'h1) begin
                  wait_r <= wait_r - 4'h1;
               end else begin
                  // data held by the device while selected [RL2]
                  if (op_r == `NVSP_OP_READ) begin
                     rsp_rdata <= data_lines_in;
                     rsp_valid <= 1'b1;
                  end
                  chip_sel_n    <= 1'b1;
                  write_n       <= 1'b1;
                  out_gate_n    <= 1'b1;
                  data_lines_oe <= 1'b0;
                  wait_r        <= 4'h0;
                  state_r       <= S_END;
               end
            end
            S_END: begin
               if (op_r == `NVSP_OP_READ || op_r == `NVSP_OP_WRITE) begin
                  state_r <= S_IDLE;
                  if (op_r == `NVSP_OP_WRITE) begin
                     rsp_valid <= 1'b1;
                  end
               end else if (step_r == 3'h5) begin
                  // grace interval is far below one wait; nv cycle starts [RL7]
                  state_r <= S_NV;
               end else if (wait_r + 4'h1 >= SP_CYC) begin
                  // spacing between sequence reads [RL12]
                  step_r   <= step_r + 3'h1;
                  mem_addr <= seq_addr;
                  state_r  <= S_SETUP;
               end else begin
                  wait_r <= wait_r + 4'h1;
               end
            end
            S_NV: begin
               // no access until the nonvolatile cycle is over [RL18]
               if (tdone) begin
                  nv_busy   <= 1'b0;
                  rsp_valid <= 1'b1;
                  state_r   <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> verilog/nvsp_map.vh
/*
 * constants for the host-side controller of the nonvolatile sram port:
 * strobe timing in ns, nonvolatile cycle durations, sequence length.
 * assumes core_clk at 25 mhz; counts are derived where they are used.
 */
`ifndef NVSP_MAP_VH
`define NVSP_MAP_VH
`define NVSP_CLK_NS            40
`define NVSP_READ_CYCLE_NS     45
`define NVSP_WRITE_PULSE_NS    30
`define NVSP_SEQ_SPACING_NS    45
`define NVSP_GRACE_NS          25
`define NVSP_STORE_MS          8
`define NVSP_RECALL_US         200
`define NVSP_PWRUP_RECALL_MS   20
`define NVSP_SEQ_LEN           6
`define NVSP_OP_READ           2'h0
`define NVSP_OP_WRITE          2'h1
`define NVSP_OP_SAVE           2'h2
`define NVSP_OP_RESTORE        2'h3
`endif

// >>> verilog/nvsp_timer.v
/*
 * nvsp_timer: loadable down counter; done is high while the count is zero.
 * assumes the caller holds load for one cycle with a nonzero value.
 */
module nvsp_timer #(
   parameter W = 20
) (
   input  wire         core_clk,
   input  wire         rst,
   input  wire         ce,
   input  wire         load,
   input  wire [W-1:0] value,
   output wire         done
);
   reg [W-1:0] cnt_r;   // remaining cycles

   // count down toward zero, reload on demand
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= {W{1'b0}};
      end else if (ce) begin
         if (load) begin
            cnt_r <= value;
         end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign done = (cnt_r == {W{1'b0}});
endmodule

// >>> verification/nvsp_dev_model.sv
/* behavioural sram side of the nonvolatile port: async reads, lanes, pull-up.
   assumes host strobes held between clock edges; no save engine modelled. */
module nvsp_dev_model #(
   parameter [107:0] SEQ_A = 108'h0,   // save sequence, entry 0 in the low bits
   parameter [107:0] SEQ_B = 108'h0    // restore sequence
) (
   input  wire        core_clk,
   input  wire [17:0] mem_addr,
   input  wire        chip_sel_n,
   input  wire        write_n,
   input  wire        out_gate_n,
   input  wire        upper_lane_sel_n,
   input  wire        lower_lane_sel_n,
   input  wire [15:0] data_lines_out,
   input  wire        data_lines_oe,
   output wire [15:0] data_lines_in,
   input  wire        hw_save_strobe_n_out,
   input  wire        hw_save_strobe_n_oe,
   output wire        hw_save_strobe_n_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];     // small window of the array
   logic [15:0] noise_r = 16'ha5c3; // floating lanes never hold last value
   logic        we_at_sel_r = 1'b0;
   logic [2:0]  seq_r  = 3'h0;   // sequence reads matched so far
   logic [3:0]  nv_r   = 4'h0;   // cycles left in the nonvolatile cycle
   logic [3:0]  boot_r = 4'h0;   // power-up restore, pin held low meanwhile
   logic        cs_q_r = 1'b1;   // select one clock ago, finds access starts
   wire         nv_run = nv_r != 4'h0;
   wire         seq_hit = mem_addr == SEQ_A[seq_r*18 +: 18] || mem_addr == SEQ_B[seq_r*18 +: 18];
   // six reads at the table addresses start a nonvolatile cycle
   always @(posedge core_clk) begin
      cs_q_r <= chip_sel_n;
      if (boot_r != 4'hf) boot_r <= boot_r + 4'h1;
      if (nv_run) nv_r <= nv_r - 4'h1;
      if (seq_r == 3'h6 && chip_sel_n) begin
         seq_r <= 3'h0;
         nv_r  <= 4'h8;   // starts once the last read has ended
      end else if (!chip_sel_n && cs_q_r) begin
         seq_r <= write_n && seq_hit ? seq_r + 3'h1 : 3'h0;
      end
   end
   wire  [15:0] rd = mem[mem_addr[7:0]];
   // write low when select falls keeps outputs off
   always @(negedge chip_sel_n) we_at_sel_r = !write_n;
   always @(posedge core_clk) begin
      noise_r <= ~noise_r;
      if (!chip_sel_n && !write_n && data_lines_oe && !nv_run) begin
         if (!lower_lane_sel_n) mem[mem_addr[7:0]][7:0] <= data_lines_out[7:0];
         if (!upper_lane_sel_n) mem[mem_addr[7:0]][15:8] <= data_lines_out[15:8];
      end
   end
   // data follows address while selected; deselect floats
   // accesses during a nonvolatile cycle see no data
   wire rd_en = !chip_sel_n && write_n && !out_gate_n && !we_at_sel_r
                && !nv_run;
   assign data_lines_in[7:0]  = rd_en && !lower_lane_sel_n ? rd[7:0] : noise_r[7:0];
   assign data_lines_in[15:8] = rd_en && !upper_lane_sel_n ? rd[15:8] : noise_r[15:8];
   // device pulls the pin low during power-up restore, then only the resistor holds it
   assign hw_save_strobe_n_in = hw_save_strobe_n_oe ? hw_save_strobe_n_out : boot_r == 4'hf;
endmodule

// >>> verification/nvsp_host_checker.sv
/* port assertions for nvsp_host: strobe order, lanes, handshake latency.
   assumes one clock domain and the read/write walk of the sequencer. */
module nvsp_host_checker #(
   parameter AW = 18
) (
   input wire          core_clk,
   input wire          rst,
   input wire          clk_en,
   input wire          req_valid,
   input wire          req_ready,
   input wire [1:0]    req_op,
   input wire [1:0]    req_lane_n,
   input wire          rsp_valid,
   input wire          nv_busy,
   input wire [AW-1:0] mem_addr,
   input wire          chip_sel_n,
   input wire          write_n,
   input wire          out_gate_n,
   input wire          upper_lane_sel_n,
   input wire          lower_lane_sel_n,
   input wire          data_lines_oe,
   input wire          hw_save_strobe_n_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !clk_en);
   wire take_rd = req_valid && req_ready && req_op == 2'h0; // read taken
   wire take_wr = req_valid && req_ready && req_op == 2'h1; // write taken
   rd_we_high_a: assert property (!chip_sel_n && !out_gate_n |-> write_n)
      else $error("write strobe low in read");
   save_pin_free_a: assert property (!hw_save_strobe_n_oe)
      else $error("save strobe driven");
   addr_hold_a: assert property (!chip_sel_n |-> $stable(mem_addr))
      else $error("address moved while selected");
   busy_block_a: assert property (nv_busy |-> !req_ready)
      else $error("ready while busy");
   rd_walk_a: assert property (take_rd |-> ##2 (!chip_sel_n && !out_gate_n)
      ##2 rsp_valid) else $error("read walk wrong");
   wr_walk_a: assert property (take_wr |-> ##2 (!chip_sel_n && !write_n && data_lines_oe)
      ##1 (chip_sel_n && write_n && !data_lines_oe) ##1 rsp_valid)
      else $error("write walk wrong");
   no_fight_a: assert property (!out_gate_n |-> !data_lines_oe)
      else $error("host drives during read");
   lane_pass_a: assert property (take_rd |-> ##2
      {upper_lane_sel_n, lower_lane_sel_n} == $past(req_lane_n, 2))
      else $error("lane selects wrong");
   cover property (take_rd);
   cover property (take_wr);
   cover property ($fell(nv_busy));
endmodule
bind nvsp_host nvsp_host_checker #(.AW(AW)) i_nvsp_host_checker (.core_clk, .rst, .clk_en, .req_valid,
   .req_ready, .req_op, .req_lane_n, .rsp_valid, .nv_busy, .mem_addr, .chip_sel_n, .write_n,
   .out_gate_n, .upper_lane_sel_n, .lower_lane_sel_n, .data_lines_oe, .hw_save_strobe_n_oe);

// >>> verification/test_nvsp_host.sv
/* self-checking bench for nvsp_host with the sram model on its pins.
   assumes short power-up and store counts set below. */
module test_nvsp_host;
   timeunit 1ns;
   timeprecision 1ps;
   localparam AW = 18;
   localparam [6*AW-1:0] SEQ  = {18'h00e38, 18'h031c7, 18'h003e0, 18'h03c1f, 18'h0303f, 18'h00c63};
   localparam [6*AW-1:0] RSEQ = {18'h00c62, SEQ[5*AW-1:0]};
   logic core_clk = 0, rst = 1, clk_en = 1, req_valid = 0;
   logic [1:0] req_op = 0, req_lane_n = 0;
   logic [AW-1:0] req_addr = 0;
   logic [15:0] req_wdata = 0, got;
   wire req_ready, rsp_valid, nv_busy, chip_sel_n, write_n, out_gate_n, data_lines_oe;
   wire upper_lane_sel_n, lower_lane_sel_n, hw_save_strobe_n_in;
   wire hw_save_strobe_n_out, hw_save_strobe_n_oe;
   wire [15:0] rsp_rdata, data_lines_in, data_lines_out;
   wire [AW-1:0] mem_addr;
   integer bad_count = 0, compares = 0, seen_n = 0, lat, i, k;
   logic [AW-1:0] seen [0:7]; // addresses at each select fall, writes included
   initial forever #20 core_clk = ~core_clk;
   nvsp_host #(.PWRUP_CYCLES(20), .STORE_CYCLES(20), .RECALL_CYCLES(10), .SAVE_SEQ(SEQ),
      .RESTORE_SEQ(RSEQ)) i_nvsp_host (.core_clk, .rst, .clk_en, .req_valid, .req_ready,
      .req_op, .req_addr, .req_wdata, .req_lane_n, .rsp_valid, .rsp_rdata, .nv_busy, .mem_addr,
      .chip_sel_n, .write_n, .out_gate_n, .upper_lane_sel_n, .lower_lane_sel_n, .data_lines_in,
      .data_lines_out, .data_lines_oe, .hw_save_strobe_n_in, .hw_save_strobe_n_out,
      .hw_save_strobe_n_oe);
   nvsp_dev_model #(.SEQ_A(SEQ), .SEQ_B(RSEQ)) i_nvsp_dev_model (.core_clk, .mem_addr,
      .chip_sel_n, .write_n, .out_gate_n, .upper_lane_sel_n, .lower_lane_sel_n, .data_lines_out,
      .data_lines_oe, .data_lines_in, .hw_save_strobe_n_out, .hw_save_strobe_n_oe,
      .hw_save_strobe_n_in);
   always @(negedge chip_sel_n) if (seen_n < 8) begin
      seen[seen_n] = mem_addr;
      seen_n = seen_n + 1;
   end
   task results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] s, input logic [31:0] e);
      compares = compares + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   // one request, held until taken; lat counts edges to the answer
   task xfer(input [1:0] op, input [AW-1:0] a, input [15:0] d, input [1:0] ln);
      integer n;
      n = 0;
      @(negedge core_clk);
      {req_valid, req_op, req_addr, req_wdata, req_lane_n} = {1'b1, op, a, d, ln};
      while (req_ready !== 1'b1 && n < 3000) begin @(negedge core_clk); n = n + 1; end
      @(posedge core_clk);
      lat = 0;
      @(negedge core_clk) req_valid = 0;
      while (rsp_valid !== 1'b1 && lat < 3000) begin @(posedge core_clk); #1 lat = lat + 1; end
      got = rsp_rdata;
      if (n >= 3000 || lat >= 3000) begin bad_count = bad_count + 1; results; end
   endtask
   task t_rw;
      xfer(2'h1, 18'h5, 16'h1234, 2'b00);
      chk("write latency", lat, 3);
      xfer(2'h0, 18'h5, 16'h0, 2'b00);
      chk("read latency", lat, 3);
      chk("read data", got, 16'h1234);
      chk("strobe pin drive", hw_save_strobe_n_oe, 0);
      chk("strobe pin level", hw_save_strobe_n_out, 1);
   endtask
   // clock enable low mid-read: the strobe phase stretches by the frozen edges
   task t_freeze;
      integer m;
      m = 0;
      fork
         xfer(2'h0, 18'h5, 16'h0, 2'b00);
         begin
            while (chip_sel_n !== 1'b0 && m < 100) begin @(negedge core_clk); m = m + 1; end
            clk_en = 0;
            repeat (3) @(negedge core_clk);
            clk_en = 1;
         end
      join
      chk("frozen read latency", lat, 6);
      chk("frozen read data", got, 16'h12ef);
      if (m >= 100) begin bad_count = bad_count + 1; results; end
   endtask
   // mid-run reset: pins idle during it, power-up wait after it
   task t_reset;
      integer n;
      @(negedge core_clk) rst = 1;
      @(negedge core_clk);
      chk("busy in reset", nv_busy, 1);
      chk("ready in reset", req_ready, 0);
      chk("select in reset", chip_sel_n, 1);
      rst = 0;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin @(posedge core_clk); #1 n = n + 1; end
      // two sync stages, one to see the pin, 20 counted, one to leave
      chk("power-up wait", n, 24);
      chk("busy after power-up", nv_busy, 0);
      if (n >= 100) results;
   endtask
   task t_lanes;
      xfer(2'h1, 18'h5, 16'hbeef, 2'b10);
      xfer(2'h0, 18'h5, 16'h0, 2'b00);
      chk("lower lane write", got, 16'h12ef);
      xfer(2'h0, 18'h5, 16'h0, 2'b01);
      chk("upper lane read", got[15:8], 8'h12);
      chk("lower lane off", got[7:0] == 8'hef, 0);
   endtask
   task t_nv;
      for (k = 2; k < 4; k = k + 1) begin
         seen_n = 0;
         xfer(k[1:0], 18'h0, 16'h0, 2'b00);
         chk("sequence reads", seen_n, 6);
         for (i = 0; i < 6; i = i + 1)
            chk("sequence address", seen[i],
                (k == 2 ? SEQ : RSEQ) >> (i * AW) & 18'h3ffff);
         chk("nv wait", lat > (k == 2 ? 20 : 10), 1);
      end
      xfer(2'h0, 18'h5, 16'h0, 2'b00);
      chk("data after nv", got, 16'h12ef);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) rst = 0;
      t_rw;
      t_lanes;
      t_freeze;
      t_nv;
      t_reset;
      results;
   end
endmodule
